// >>> common/pcm_pkg.sv
/*
  Package for the configuration status mirror: register map of the local
  register port, field positions, reset values and interrupt layout.
  Assumes a 25 MHz user clock and a single-cycle register port.
*/
package pcm_pkg;
  // ********************************************************
  // Sizes
  // ********************************************************
  localparam int PCM_NUM_PF = 2;
  localparam int PCM_NUM_VF = 6;
  localparam int PCM_ST_W = 3;
  localparam int PCM_ADDR_W = 8;
  localparam int PCM_DATA_W = 32;

  // ********************************************************
  // Register offsets (byte addresses, one word each)
  // ********************************************************
  localparam logic [7:0] PCM_CTRL_OFF = 8'h00;
  localparam logic [7:0] PCM_PF0_OFF = 8'h04;
  localparam logic [7:0] PCM_PF1_OFF = 8'h08;
  localparam logic [7:0] PCM_VF_EN_OFF = 8'h0C;
  localparam logic [7:0] PCM_VF_ST_OFF = 8'h10;
  localparam logic [7:0] PCM_LNK_CTRL_OFF = 8'h14;
  localparam logic [7:0] PCM_LNK_STAT_OFF = 8'h18;
  localparam logic [7:0] PCM_IRQ_STAT_OFF = 8'h1C;
  localparam logic [7:0] PCM_IRQ_MASK_OFF = 8'h20;
  localparam logic [7:0] PCM_OUT_OFF = 8'h24;

  // ********************************************************
  // Field positions
  // ********************************************************
  // CTRL: bit0 root port mode, bits 2:1 buffer flush/fill enable
  localparam int PCM_CTRL_RP_BIT = 0;
  localparam int PCM_CTRL_OBFF_LSB = 1;
  // PF words: bit0 completion boundary, bits 3:1 power state, bits 6:4 steering mode, bit 8 requester on
  localparam int PCM_PF_RCB_BIT = 0;
  localparam int PCM_PF_DPA_LSB = 1;
  localparam int PCM_PF_ST_LSB = 4;
  localparam int PCM_PF_REQ_BIT = 8;
  // Link control: rp completion boundary, interrupt enables
  localparam int PCM_LC_RCB_BIT = 0;
  localparam int PCM_LC_BWM_IE_BIT = 1;
  localparam int PCM_LC_ABW_IE_BIT = 2;
  localparam int PCM_LC_EQ_IE_BIT = 3;
  // Link status: sticky event bits, also interrupt status layout
  localparam int PCM_LS_BWM_BIT = 0;
  localparam int PCM_LS_ABW_BIT = 1;
  localparam int PCM_LS_EQ_BIT = 2;
  localparam int PCM_LS_W = 3;
  // Interrupt status: link bits 2:0, power state change PF0/PF1 bits 4:3
  localparam int PCM_IRQ_DPA_LSB = 3;
  localparam int PCM_IRQ_W = 5;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [31:0] PCM_WORD_RST = 32'h0000_0000;
  localparam logic [4:0] PCM_IRQ_MASK_RST = 5'h00;
endpackage

// >>> rtl/pcm_status_mirror.sv
/*
  Configuration status mirror: holds mirrored configuration settings written
  over a local register port and drives them to the user logic outputs, with
  link event and power state change signalling.
  Assumes all inputs synchronous to mclk_i and a master that never waits.
*/
`timescale 1ns/1ns
// Behaviour
// - Endpoint: completion boundary flag per PF, bit0 PF0, bit1 PF1.
// - Root port: bit0 from root port link control, bit1 reserved zero.
// - Boundary flag zero means 64 bytes, one means 128 bytes.
// - Endpoint: power state change by config write pulses that PF bit once.
// - Root port: power state change outputs stay low.
// - Two-bit flush/fill enable field presented as written.
// - Root port: local bandwidth change sets status, raises event if enabled.
// - Root port: autonomous bandwidth change sets status, raises event if enabled.
// - Root port: equalization request sets status bit, raises event if enabled.
// - Endpoint never asserts the link event output.
// - Requester enable output mirrors bit 8 of each PF control.
// - Six-bit steering mode, PF0 in bits 2:0, PF1 in 5:3.
// - Six VF requester enable bits, bit n of the VF enable word for VF n.
// - Eighteen-bit VF steering mode, three bits per VF upward.
// - Root port reports bus master enable and interrupt disable as zero.
module pcm_status_mirror
  import pcm_pkg::*;
#(
  parameter int NUM_VF = PCM_NUM_VF
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [PCM_ADDR_W-1:0] reg_addr_i,
  input wire logic [PCM_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [PCM_DATA_W-1:0] reg_rdata_o,
  input wire logic bus_master_en_i,
  input wire logic intx_disable_i,
  input wire logic local_bw_change_i,
  input wire logic auto_bw_change_i,
  input wire logic eq_request_i,
  output logic [PCM_NUM_PF-1:0] rcb_status_o,
  output logic [PCM_NUM_PF-1:0] dpa_substate_change_o,
  output logic [1:0] obff_enable_o,
  output logic link_event_change_o,
  output logic [PCM_NUM_PF-1:0] pf_hint_requester_on_o,
  output logic [PCM_NUM_PF*PCM_ST_W-1:0] pf_steering_tag_mode_o,
  output logic [NUM_VF-1:0] vfn_hint_requester_on_o,
  output logic [NUM_VF*PCM_ST_W-1:0] vfn_steering_tag_mode_o,
  output logic bus_master_en_o,
  output logic intx_disable_o,
  output logic irq_o
);
  // ********************************************************
  // Storage
  // ********************************************************
  logic [PCM_DATA_W-1:0] ctrl_q;
  logic [PCM_DATA_W-1:0] pf_q [PCM_NUM_PF];
  logic [NUM_VF-1:0] vf_en_q;
  logic [NUM_VF*PCM_ST_W-1:0] vf_st_q;
  logic [PCM_DATA_W-1:0] lnk_ctrl_q;
  logic [PCM_LS_W-1:0] lnk_stat_q;
  logic [PCM_LS_W-1:0] lnk_stat_d;
  logic [PCM_IRQ_W-1:0] irq_stat_q;
  logic [PCM_IRQ_W-1:0] irq_stat_d;
  logic [PCM_IRQ_W-1:0] irq_mask_q;
  logic [PCM_NUM_PF-1:0] dpa_pulse_d;

  // ********************************************************
  // Decode
  // ********************************************************
  wire rp_mode = ctrl_q[PCM_CTRL_RP_BIT];
  wire wr_ctrl = reg_wr_i && (reg_addr_i == PCM_CTRL_OFF);
  wire wr_vf_en = reg_wr_i && (reg_addr_i == PCM_VF_EN_OFF);
  wire wr_vf_st = reg_wr_i && (reg_addr_i == PCM_VF_ST_OFF);
  wire wr_lnk_ctrl = reg_wr_i && (reg_addr_i == PCM_LNK_CTRL_OFF);
  wire wr_lnk_stat = reg_wr_i && (reg_addr_i == PCM_LNK_STAT_OFF);
  wire wr_irq_stat = reg_wr_i && (reg_addr_i == PCM_IRQ_STAT_OFF);
  wire wr_irq_mask = reg_wr_i && (reg_addr_i == PCM_IRQ_MASK_OFF);
  wire [PCM_NUM_PF-1:0] wr_pf;
  wire [2:0] pf_dpa_new [PCM_NUM_PF];
  wire [2:0] pf_dpa_old [PCM_NUM_PF];

  // Link events only exist in root port mode
  wire [PCM_LS_W-1:0] lnk_evt = rp_mode ? {eq_request_i, auto_bw_change_i, local_bw_change_i}
                                        : '0;
  wire [PCM_LS_W-1:0] lnk_ie = {lnk_ctrl_q[PCM_LC_EQ_IE_BIT], lnk_ctrl_q[PCM_LC_ABW_IE_BIT],
                                lnk_ctrl_q[PCM_LC_BWM_IE_BIT]};
  // Event output follows enabled, recorded link status
  wire link_evt_d = rp_mode && |(lnk_stat_d & lnk_ie);

  // ********************************************************
  // Per-function write and power state compare
  // ********************************************************
  genvar g;
  generate
    for (g = 0; g < PCM_NUM_PF; g++) begin : g_pf
      assign wr_pf[g] = reg_wr_i && (reg_addr_i == (g == 0 ? PCM_PF0_OFF : PCM_PF1_OFF));
      assign pf_dpa_new[g] = reg_wdata_i[PCM_PF_DPA_LSB +: 3];
      assign pf_dpa_old[g] = pf_q[g][PCM_PF_DPA_LSB +: 3];
      // Only a write that alters the state counts, rewriting the same value is silent
      assign dpa_pulse_d[g] = !rp_mode && wr_pf[g] && (pf_dpa_new[g] != pf_dpa_old[g]);
      always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          pf_q[g] <= PCM_WORD_RST;
        end else if (wr_pf[g]) begin
          pf_q[g] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // ********************************************************
  // Sticky status bits
  // ********************************************************
  // Hardware set wins over the write-one clear, so an event is never lost
  wire [PCM_IRQ_W-1:0] irq_set = {dpa_pulse_d, lnk_evt};
  genvar b;
  generate
    for (b = 0; b < PCM_IRQ_W; b++) begin : g_stat
      wire irq_clr = wr_irq_stat && reg_wdata_i[b];
      assign irq_stat_d[b] = irq_set[b] || (irq_stat_q[b] && !irq_clr);
      if (b < PCM_LS_W) begin : g_lnk
        wire lnk_clr = wr_lnk_stat && reg_wdata_i[b];
        assign lnk_stat_d[b] = lnk_evt[b] || (lnk_stat_q[b] && !lnk_clr);
      end
    end
  endgenerate

  // ********************************************************
  // Read mux
  // ********************************************************
  logic [PCM_DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (reg_addr_i)
      PCM_CTRL_OFF: rd_mux = ctrl_q;
      PCM_PF0_OFF: rd_mux = pf_q[0];
      PCM_PF1_OFF: rd_mux = pf_q[1];
      PCM_VF_EN_OFF: rd_mux[NUM_VF-1:0] = vf_en_q;
      PCM_VF_ST_OFF: rd_mux[NUM_VF*PCM_ST_W-1:0] = vf_st_q;
      PCM_LNK_CTRL_OFF: rd_mux = lnk_ctrl_q;
      PCM_LNK_STAT_OFF: rd_mux[PCM_LS_W-1:0] = lnk_stat_q;
      PCM_IRQ_STAT_OFF: rd_mux[PCM_IRQ_W-1:0] = irq_stat_q;
      PCM_IRQ_MASK_OFF: rd_mux[PCM_IRQ_W-1:0] = irq_mask_q;
      PCM_OUT_OFF: rd_mux[7:0] = {link_event_change_o, obff_enable_o, intx_disable_o,
                                  bus_master_en_o, dpa_substate_change_o, irq_o};
      default: rd_mux = '0;
    endcase
  end

  // ********************************************************
  // Output values
  // ********************************************************
  // Root port takes its boundary from its own link control, bit1 reserved
  wire [PCM_NUM_PF-1:0] rcb_d = rp_mode ? {1'b0, lnk_ctrl_q[PCM_LC_RCB_BIT]}
                                        : {pf_q[1][PCM_PF_RCB_BIT], pf_q[0][PCM_PF_RCB_BIT]};
  wire [PCM_NUM_PF-1:0] req_d = {pf_q[1][PCM_PF_REQ_BIT], pf_q[0][PCM_PF_REQ_BIT]};
  wire [PCM_NUM_PF*PCM_ST_W-1:0] st_d = {pf_q[1][PCM_PF_ST_LSB +: PCM_ST_W],
                                         pf_q[0][PCM_PF_ST_LSB +: PCM_ST_W]};
  wire [1:0] obff_d = ctrl_q[PCM_CTRL_OBFF_LSB +: 2];
  // Root port command bits do not apply, so they read as zero
  wire bme_d = bus_master_en_i && !rp_mode;
  wire intx_d = intx_disable_i && !rp_mode;
  wire irq_d = |(irq_stat_d & irq_mask_q);
  wire [PCM_DATA_W-1:0] rdata_d = reg_rd_i ? rd_mux : '0;

  // Per-VF slices: VF n owns requester bit n and mode bits 3n+2:3n
  wire [NUM_VF-1:0] vf_req_d;
  wire [NUM_VF*PCM_ST_W-1:0] vf_st_d;
  genvar v;
  generate
    for (v = 0; v < NUM_VF; v++) begin : g_vf
      assign vf_req_d[v] = vf_en_q[v];
      assign vf_st_d[v*PCM_ST_W +: PCM_ST_W] = vf_st_q[v*PCM_ST_W +: PCM_ST_W];
    end
  endgenerate

  // ********************************************************
  // Settings registers
  // ********************************************************
  // Control, PF and link control words are kept whole so software reads back what it wrote
  // Unmapped addresses match no decode and are dropped
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= PCM_WORD_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vf_en_q <= '0;
    end else if (wr_vf_en) begin
      vf_en_q <= reg_wdata_i[NUM_VF-1:0];
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vf_st_q <= '0;
    end else if (wr_vf_st) begin
      vf_st_q <= reg_wdata_i[NUM_VF*PCM_ST_W-1:0];
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lnk_ctrl_q <= PCM_WORD_RST;
    end else if (wr_lnk_ctrl) begin
      lnk_ctrl_q <= reg_wdata_i;
    end
  end

  // Mask resets to zero so nothing interrupts before software opts in
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_mask_q <= PCM_IRQ_MASK_RST;
    end else if (wr_irq_mask) begin
      irq_mask_q <= reg_wdata_i[PCM_IRQ_W-1:0];
    end
  end

  // ********************************************************
  // Link status
  // ********************************************************
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lnk_stat_q <= '0;
    end else begin
      lnk_stat_q <= lnk_stat_d;
    end
  end

  // ********************************************************
  // Interrupt status
  // ********************************************************
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // ********************************************************
  // Read port
  // ********************************************************
  // Read data is zero outside its answer cycle
  // Reads have no side effects, so a repeated read is harmless
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= rdata_d;
    end
  end

  // ********************************************************
  // Interrupt output
  // ********************************************************
  // Taken from the next status so it lines up with the stored bits
  // One level output covers every unmasked status bit
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_d;
    end
  end

  // ********************************************************
  // Completion boundary
  // ********************************************************
  // Mirrors follow the stored setting one cycle later
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rcb_status_o <= '0;
    end else begin
      rcb_status_o <= rcb_d;
    end
  end

  // ********************************************************
  // Power state pulses
  // ********************************************************
  // Pulse lasts one cycle since the compare sees the write only once
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dpa_substate_change_o <= '0;
    end else begin
      dpa_substate_change_o <= dpa_pulse_d;
    end
  end

  // ********************************************************
  // Flush fill and link event
  // ********************************************************
  // Field passes through unchanged, all four codes are legal
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      obff_enable_o <= 2'h0;
    end else begin
      obff_enable_o <= obff_d;
    end
  end

  // Level, dropped by the write-one clear of the link status, by clearing the enable or by leaving root port mode
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link_event_change_o <= 1'b0;
    end else begin
      link_event_change_o <= link_evt_d;
    end
  end

  // ********************************************************
  // Physical function hints
  // ********************************************************
  // Bit 8 and the mode field of each function word, no decoding
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pf_hint_requester_on_o <= '0;
    end else begin
      pf_hint_requester_on_o <= req_d;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pf_steering_tag_mode_o <= '0;
    end else begin
      pf_steering_tag_mode_o <= st_d;
    end
  end

  // ********************************************************
  // Virtual function hints
  // ********************************************************
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vfn_hint_requester_on_o <= '0;
    end else begin
      vfn_hint_requester_on_o <= vf_req_d;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vfn_steering_tag_mode_o <= '0;
    end else begin
      vfn_steering_tag_mode_o <= vf_st_d;
    end
  end

  // ********************************************************
  // Command bits
  // ********************************************************
  // Endpoint passes the command bits through one flop
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bus_master_en_o <= 1'b0;
    end else begin
      bus_master_en_o <= bme_d;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      intx_disable_o <= 1'b0;
    end else begin
      intx_disable_o <= intx_d;
    end
  end
endmodule

// >>> verification/pcm_status_mirror_sva.sv
/*
  Port checker for the configuration status mirror.
  Assumes one clock domain and a bind to pcm_status_mirror.
*/
`timescale 1ns/1ns
module pcm_status_mirror_sva
  import pcm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [PCM_ADDR_W-1:0] reg_addr_i,
  input wire logic [PCM_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [PCM_DATA_W-1:0] reg_rdata_o,
  input wire logic eq_request_i,
  input wire logic [PCM_NUM_PF-1:0] rcb_status_o,
  input wire logic [PCM_NUM_PF-1:0] dpa_substate_change_o,
  input wire logic [1:0] obff_enable_o,
  input wire logic link_event_change_o,
  input wire logic [PCM_NUM_PF-1:0] pf_hint_requester_on_o,
  input wire logic bus_master_en_o,
  input wire logic intx_disable_o,
  input wire logic irq_o
);
  // ********************************************************
  // Shadow copies of written words, same timing as the design
  // ********************************************************
  logic [31:0] ctrl_q, pf0_q, lc_q;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= '0;
      pf0_q <= '0;
      lc_q <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == PCM_CTRL_OFF) ctrl_q <= reg_wdata_i;
      if (reg_addr_i == PCM_PF0_OFF) pf0_q <= reg_wdata_i;
      if (reg_addr_i == PCM_LNK_CTRL_OFF) lc_q <= reg_wdata_i;
    end
  end
  wire rp_w = ctrl_q[PCM_CTRL_RP_BIT];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0) else $error("read data not idle");
  dpa_cause_a: assert property (dpa_substate_change_o[0] |->
    $past(reg_wr_i) && $past(reg_addr_i) == PCM_PF0_OFF && !$past(rp_w)) else $error("power pulse without cause");
  dpa_quiet_a: assert property ($past(rp_w) |-> dpa_substate_change_o == '0) else $error("power pulse in rp");
  rcb_rp_a: assert property ($past(rp_w) |-> rcb_status_o == {1'b0, $past(lc_q[0])}) else $error("rp boundary");
  rcb_ep_a: assert property (!$past(rp_w) |-> rcb_status_o[0] == $past(pf0_q[0])) else $error("ep boundary");
  ctl_zero_a: assert property ($past(rp_w) |-> !bus_master_en_o && !intx_disable_o) else $error("rp controls");
  link_ep_a: assert property (!$past(rp_w) |-> !link_event_change_o) else $error("link event in ep");
  obff_copy_a: assert property (obff_enable_o == $past(ctrl_q[2:1])) else $error("flush fill field");
  req_copy_a: assert property (pf_hint_requester_on_o[0] == $past(pf0_q[8])) else $error("requester bit");
  eq_event_a: assert property (eq_request_i && rp_w && lc_q[3] && !reg_wr_i |-> ##1 link_event_change_o)
    else $error("eq event missing");
  cover property (dpa_substate_change_o[0]);
  cover property (link_event_change_o);
  cover property (irq_o);
endmodule
bind pcm_status_mirror pcm_status_mirror_sva chk_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .eq_request_i(eq_request_i), .rcb_status_o(rcb_status_o),
  .dpa_substate_change_o(dpa_substate_change_o), .obff_enable_o(obff_enable_o),
  .link_event_change_o(link_event_change_o), .pf_hint_requester_on_o(pf_hint_requester_on_o),
  .bus_master_en_o(bus_master_en_o), .intx_disable_o(intx_disable_o), .irq_o(irq_o));

// >>> verification/pcm_user_model.sv
/*
  User logic model: counts power state change pulses it receives.
  Assumes pulses are sampled on mclk_i like real user logic.
*/
`timescale 1ns/1ns
module pcm_user_model (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] dpa_i,
  output logic [7:0] dpa_cnt_o
);
  // A stretched pulse counts twice, so the bench sees it
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) dpa_cnt_o <= 8'h00;
    else dpa_cnt_o <= dpa_cnt_o + 8'(dpa_i[0]) + 8'(dpa_i[1]);
  end
endmodule

// >>> verification/pcm_status_mirror_tb.sv
/*
  Bench for the status mirror: register tasks, mirror and event checks.
  Assumes the design answers reads one cycle after the strobe.
*/
`timescale 1ns/1ns
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %0h got %0h", nm, e, a); end end
module pcm_status_mirror_tb import pcm_pkg::*;;
  logic mclk = 0, rst = 1, wr_s = 0, rd_s = 0, bme = 0, intx = 0;
  logic [2:0] ev = '0;
  logic [7:0] addr = '0, cnt;
  logic [31:0] wdata = '0, rdata;
  logic [1:0] rcb, dpa, obff, req;
  logic [5:0] st, vreq;
  logic [17:0] vst;
  logic lnk, bmeo, intxo, irq;
  int mismatches = 0, n_compared = 0, cyc = 0, i;
  pcm_status_mirror dut_u (.mclk_i(mclk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .bus_master_en_i(bme), .intx_disable_i(intx),
    .local_bw_change_i(ev[0]), .auto_bw_change_i(ev[1]), .eq_request_i(ev[2]), .rcb_status_o(rcb),
    .dpa_substate_change_o(dpa), .obff_enable_o(obff), .link_event_change_o(lnk),
    .pf_hint_requester_on_o(req), .pf_steering_tag_mode_o(st), .vfn_hint_requester_on_o(vreq),
    .vfn_steering_tag_mode_o(vst), .bus_master_en_o(bmeo), .intx_disable_o(intxo), .irq_o(irq));
  pcm_user_model user_u (.mclk_i(mclk), .sys_rst_i(rst), .dpa_i(dpa), .dpa_cnt_o(cnt));
  initial begin
    forever #20 mclk = ~mclk;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk) wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk) addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk) rd_s <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic pulse(input int k);
    @(posedge mclk) ev <= 3'h1 << k;
    @(posedge mclk) ev <= 3'h0;
    settle();
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Ceiling is over twenty times the expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    bme <= 1'b1;
    intx <= 1'b1;
    for (i = 0; i < 10; i++) rd(8'(4 * i), (i == 9) ? 32'h18 : 32'h0);
    wr(PCM_PF0_OFF, 32'h157);
    wr(PCM_PF1_OFF, 32'h125);
    settle();
    `CHK("dpa count", 8'h02, cnt)
    `CHK("rcb", 2'h3, rcb)
    `CHK("req", 2'h3, req)
    `CHK("st", 6'h15, st)
    `CHK("bme ep", 1'b1, bmeo)
    wr(PCM_PF0_OFF, 32'h057);
    settle();
    `CHK("dpa same", 8'h02, cnt)
    `CHK("req off", 2'h2, req)
    wr(PCM_VF_EN_OFF, 32'h2D);
    wr(PCM_VF_ST_OFF, 32'h2A5C3);
    wr(8'h30, 32'hFF);
    settle();
    `CHK("vf req", 6'h2D, vreq)
    `CHK("vf st", 18'h2A5C3, vst)
    rd(8'h30, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(PCM_CTRL_OFF, 32'(i << 1));
      settle();
      `CHK("obff", 2'(i), obff)
    end
    rd(PCM_IRQ_STAT_OFF, 32'h18);
    wr(PCM_IRQ_MASK_OFF, 32'h08);
    settle();
    `CHK("irq on", 1'b1, irq)
    wr(PCM_IRQ_STAT_OFF, 32'h08);
    settle();
    `CHK("irq off", 1'b0, irq)
    rd(PCM_IRQ_STAT_OFF, 32'h10);
    wr(PCM_LNK_CTRL_OFF, 32'h0F);
    pulse(2);
    `CHK("link ep", 1'b0, lnk)
    wr(PCM_CTRL_OFF, 32'h1);
    settle();
    `CHK("rcb rp", 2'h1, rcb)
    `CHK("bme rp", 1'b0, bmeo)
    `CHK("intx rp", 1'b0, intxo)
    wr(PCM_PF1_OFF, 32'h123);
    settle();
    `CHK("dpa rp", 8'h02, cnt)
    for (i = 0; i < 3; i++) begin
      pulse(i);
      `CHK("link rp", 1'b1, lnk)
      rd(PCM_LNK_STAT_OFF, 32'h1 << i);
      wr(PCM_LNK_STAT_OFF, 32'h1 << i);
      settle();
      `CHK("link clr", 1'b0, lnk)
    end
    wr(PCM_LNK_CTRL_OFF, 32'h1);
    pulse(0);
    `CHK("link masked", 1'b0, lnk)
    rd(PCM_LNK_STAT_OFF, 32'h1);
    wrap_up();
  end
endmodule
